// ==== pssl_power_status_regs.v ====
// The APB interface to the registers is this design's own decision.
`include "pssl_regs.vh"
`default_nettype none
// Function
// - status bit 24 is high while the on-chip oscillator is stable, read-only.
// - status bit 19 is high while the pll supply rail is good, read-only.
// - status bit 16 is high while the core supply rail is good, read-only.
// - bits 8 and 9 show the core and analog converters limiting current.
// - bits 0 and 1 show the core and analog converters in soft-start.
// - a 7-bit core level in bits 6:0 selects 0.60 V plus code times 10 mV.
// - both level fields take their reset value from the mode strap decode.
// - a 3-bit pll regulator level in bits 2:0 selects 0.6 V plus code times 100 mV.
module pssl_power_status_regs #(
   parameter [`PSSL_CORE_LVL_W-1:0] CORE_LVL_STRAP0 = 7'h28,
   parameter [`PSSL_CORE_LVL_W-1:0] CORE_LVL_STRAP1 = 7'h28,
   parameter [`PSSL_PLL_LVL_W-1:0]  PLL_LVL_STRAP0  = 3'h4,
   parameter [`PSSL_PLL_LVL_W-1:0]  PLL_LVL_STRAP1  = 3'h4
) (
   input  wire        ref_clk,
   input  wire        nrst,
   input  wire [11:0] paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [1:0]  modeStrap,
   input  wire        oscStable,
   input  wire        pllSupplyRailGood,
   input  wire        coreSupplyRailGood,
   input  wire        coreConverterLimit,
   input  wire        analogConverterLimit,
   input  wire        coreConverterSoftStart,
   input  wire        analogConverterSoftStart,
   output reg  [6:0]  coreLevel,
   output reg  [2:0]  pllRegulatorLevel,
   output reg         irq
);
   // ----------------------------------------
   // status snapshot
   // ----------------------------------------
   reg  [31:0] status_r;
   reg         strapDone_r;
   reg  [`PSSL_NUM_EVENTS-1:0] intMask_r;
   wire [`PSSL_NUM_EVENTS-1:0] evtSrc;
   wire [`PSSL_NUM_EVENTS-1:0] evtSticky;
   wire [31:0] statusNxt;
   wire        setupPhase;
   wire        wrAccess;
   wire        rdAccess;
   wire        clrEvents;
   reg  [31:0] rdData_nxt;
   reg         decErr_nxt;

   // live levels packed at their documented positions, reserved bits zero
   assign statusNxt = {7'h00, oscStable, 4'h0, pllSupplyRailGood, 2'h0,
                       coreSupplyRailGood, 6'h00, analogConverterLimit,
                       coreConverterLimit, 6'h00, analogConverterSoftStart,
                       coreConverterSoftStart};

   // registered once so reads and events see one coherent sample
   always @(posedge ref_clk) begin
      if (!nrst) begin
         status_r <= 32'h00000000;
      end else begin
         status_r <= statusNxt;
      end
   end

   // ----------------------------------------
   // event sticky bits
   // ----------------------------------------
   // each status condition raises an event when it comes on
   assign evtSrc = {status_r[`PSSL_BIT_OSC_STABLE], status_r[`PSSL_BIT_PLL_GOOD],
                    status_r[`PSSL_BIT_CORE_GOOD], status_r[`PSSL_BIT_ANA_LIMIT],
                    status_r[`PSSL_BIT_CORE_LIMIT], status_r[`PSSL_BIT_ANA_SOFT],
                    status_r[`PSSL_BIT_CORE_SOFT]};

   genvar gi;
   generate
      for (gi = 0; gi < `PSSL_NUM_EVENTS; gi = gi + 1) begin : gEvt
         pssl_event_bit uEvt (
            .ref_clk    (ref_clk),
            .nrst       (nrst),
            .srcLevel   (evtSrc[gi]),
            .clearPulse (clrEvents),
            .stickyBit  (evtSticky[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   // zero wait states: pready is high in every access phase
   assign setupPhase = psel && !penable;
   assign wrAccess   = psel && penable && pready && pwrite;
   assign rdAccess   = psel && penable && pready && !pwrite;
   assign clrEvents  = rdAccess && (paddr == `PSSL_OFS_INT_STAT) && !pslverr;

   // read mux and unmapped-address check, evaluated in the setup phase
   always @* begin
      rdData_nxt = 32'h00000000;
      decErr_nxt = 1'b0;
      if (paddr == `PSSL_OFS_STATUS) begin
         rdData_nxt = status_r;
      end else if (paddr == `PSSL_OFS_CORE_LVL) begin
         rdData_nxt = {25'h0000000, coreLevel};
      end else if (paddr == `PSSL_OFS_PLL_LVL) begin
         rdData_nxt = {29'h00000000, pllRegulatorLevel};
      end else if (paddr == `PSSL_OFS_INT_STAT) begin
         rdData_nxt = {25'h0000000, evtSticky};
      end else if (paddr == `PSSL_OFS_INT_MASK) begin
         rdData_nxt = {25'h0000000, intMask_r};
      end else begin
         decErr_nxt = 1'b1;
      end
   end

   // answer registered in the setup cycle, held through the access phase
   always @(posedge ref_clk) begin
      if (!nrst) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (setupPhase) begin
         prdata  <= pwrite ? 32'h00000000 : rdData_nxt;
         pready  <= 1'b1;
         pslverr <= decErr_nxt;
      end else begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ----------------------------------------
   // level registers
   // ----------------------------------------
   // strap decode: the level fields load once, in the first cycle after reset release,
   // because a synchronous reset must not copy a pin value directly
   always @(posedge ref_clk) begin
      if (!nrst) begin
         strapDone_r       <= 1'b0;
         coreLevel         <= 7'h00;
         pllRegulatorLevel <= 3'h0;
      end else if (!strapDone_r) begin
         strapDone_r       <= 1'b1;
         coreLevel         <= modeStrap[0] ? CORE_LVL_STRAP1 : CORE_LVL_STRAP0;
         pllRegulatorLevel <= modeStrap[0] ? PLL_LVL_STRAP1 : PLL_LVL_STRAP0;
      end else if (wrAccess && !pslverr && pstrb[0]) begin
         // slew and step limits are left to software; any code is taken as written
         if (paddr == `PSSL_OFS_CORE_LVL) begin
            coreLevel <= pwdata[`PSSL_CORE_LVL_W-1:0];
         end else if (paddr == `PSSL_OFS_PLL_LVL) begin
            pllRegulatorLevel <= pwdata[`PSSL_PLL_LVL_W-1:0];
         end
      end
   end

   // ----------------------------------------
   // interrupt mask and output
   // ----------------------------------------
   always @(posedge ref_clk) begin
      if (!nrst) begin
         intMask_r <= 7'h00;
      end else if (wrAccess && !pslverr && pstrb[0] && (paddr == `PSSL_OFS_INT_MASK)) begin
         intMask_r <= pwdata[`PSSL_NUM_EVENTS-1:0];
      end
   end

   // level output, one cycle behind the sticky bits
   always @(posedge ref_clk) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(evtSticky & intMask_r);
      end
   end
endmodule // pssl_power_status_regs
`default_nettype wire

// ==== pssl_regs.vh ====
`ifndef PSSL_REGS_VH
`define PSSL_REGS_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define PSSL_OFS_STATUS    12'h030
`define PSSL_OFS_CORE_LVL  12'h034
`define PSSL_OFS_PLL_LVL   12'h040
`define PSSL_OFS_INT_STAT  12'h050
`define PSSL_OFS_INT_MASK  12'h054
// ----------------------------------------
// status field positions
// ----------------------------------------
`define PSSL_BIT_OSC_STABLE  24
`define PSSL_BIT_PLL_GOOD    19
`define PSSL_BIT_CORE_GOOD   16
`define PSSL_BIT_ANA_LIMIT   9
`define PSSL_BIT_CORE_LIMIT  8
`define PSSL_BIT_ANA_SOFT    1
`define PSSL_BIT_CORE_SOFT   0
// ----------------------------------------
// level field widths and steps
// ----------------------------------------
`define PSSL_CORE_LVL_W    7
`define PSSL_PLL_LVL_W     3
`define PSSL_CORE_BASE_MV  600
`define PSSL_CORE_STEP_MV  10
`define PSSL_PLL_BASE_MV   600
`define PSSL_PLL_STEP_MV   100
`define PSSL_NUM_EVENTS    7
`endif

// ==== pssl_event_bit.v ====
`default_nettype none
// one sticky event bit: set on a rising edge of its source, cleared by a read of the interrupt status register
module pssl_event_bit (
   input  wire ref_clk,
   input  wire nrst,
   input  wire srcLevel,
   input  wire clearPulse,
   output reg  stickyBit
);
   reg srcLevel_r;

   // set wins over clear so an edge in the clearing cycle is kept
   always @(posedge ref_clk) begin
      if (!nrst) begin
         srcLevel_r <= 1'b0;
         stickyBit  <= 1'b0;
      end else begin
         srcLevel_r <= srcLevel;
         if (srcLevel && !srcLevel_r) begin
            stickyBit <= 1'b1;
         end else if (clearPulse) begin
            stickyBit <= 1'b0;
         end
      end
   end
endmodule // pssl_event_bit
`default_nettype wire

// ==== pssl_regs_asserts.sv ====
`default_nettype none
module pssl_regs_asserts (
   input wire logic        ref_clk,
   input wire logic        nrst,
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [6:0]  coreLevel
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------
   // access decode
   // ----------------
   wire logic acc;
   wire logic rd;
   wire logic map;
   // completed access phase; map also holds the chosen event offsets
   assign acc = psel & penable & pready;
   assign rd = acc & ~pwrite;
   assign map = paddr inside {12'h030, 12'h034, 12'h040, 12'h050, 12'h054};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   unmapped_err_a: assert property (acc && !map |-> pslverr)
      else $error("unmapped access not refused");
   idle_quiet_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
      else $error("bus outputs not quiet");
   stat_rsvd_a: assert property (rd && paddr == 12'h030 |-> (prdata & 32'hFEF6FCFC) == 32'h0)
      else $error("status reserved bits set");
   core_rsvd_a: assert property (rd && paddr == 12'h034 |-> prdata[31:7] == 25'h0)
      else $error("core level reserved bits set");
   pll_rsvd_a: assert property (rd && paddr == 12'h040 |-> prdata[31:3] == 29'h0)
      else $error("pll level reserved bits set");
   core_read_a: assert property (rd && paddr == 12'h034 |-> prdata[6:0] == coreLevel)
      else $error("core level readback wrong");
   core_write_a: assert property (acc && pwrite && paddr == 12'h034 && pstrb[0]
      |=> coreLevel == $past(pwdata[6:0]))
      else $error("core level write lost");
endmodule // pssl_regs_asserts
bind pssl_power_status_regs pssl_regs_asserts u_chk (.ref_clk, .nrst, .paddr, .psel,
   .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .coreLevel);
`default_nettype wire

// ==== tb_power_supply_status_level_regs.sv ====
`default_nettype none
module tb_power_supply_status_level_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, e;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, r, prdata;
   logic [6:0]  st = '0, c = 7'h46, coreLevel;
   logic [2:0]  p = 3'h7, t, pllRegulatorLevel;
   logic [3:0]  ps = 4'hF;
   logic [1:0]  ms = 2'h1;
   logic        pready, pslverr, irq;
   int          seed = 32'he1fabe6f, bad_count = 0, cmp_count = 0, i;
   // strap 1 selected: distinct values per strap expose a wrong pick
   pssl_power_status_regs #(.CORE_LVL_STRAP0(7'h11), .CORE_LVL_STRAP1(7'h46),
      .PLL_LVL_STRAP0(3'h2), .PLL_LVL_STRAP1(3'h7)) dut (.ref_clk, .nrst, .paddr, .psel,
      .penable, .pwrite, .pwdata, .pstrb(ps), .prdata, .pready, .pslverr,
      .modeStrap(ms), .oscStable(st[6]), .pllSupplyRailGood(st[5]),
      .coreSupplyRailGood(st[4]), .analogConverterLimit(st[3]), .coreConverterLimit(st[2]),
      .analogConverterSoftStart(st[1]), .coreConverterSoftStart(st[0]), .coreLevel,
      .pllRegulatorLevel, .irq);
   // free-running reference clock
   initial forever #10 ref_clk = ~ref_clk;
   // ----------------
   // helpers
   // ----------------
   task chk(input logic [31:0] s, input logic [31:0] x);
      cmp_count++;
      if (s !== x) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task print_verdict;
      $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // one apb transfer; idle edge after it so psel is never set twice at one step
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         print_verdict();
      end
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge ref_clk);
   endtask
   // status layout: fields scattered, everything else zero
   function logic [31:0] exp_stat(input logic [6:0] v);
      return {7'h0, v[6], 4'h0, v[5], 2'h0, v[4], 6'h0, v[3:2], 6'h0, v[1:0]};
   endfunction
   // ----------------
   // main sequence
   // ----------------
   initial begin
      repeat (3) @(posedge ref_clk);
      nrst <= 1;
      repeat (2) @(posedge ref_clk);
      apb(0, 12'h034, 0);
      chk(r, 32'h46);
      apb(0, 12'h040, 0);
      chk(r, 32'h7);
      // one code per step, a microsecond of idle between steps; pll only rises by one
      for (i = 0; i < 10; i++) begin
         c = ($random(seed) & 1) ? c + 7'h1 : c - 7'h1;
         t = 3'($random(seed));
         p = (t > p) ? p + 3'h1 : t;
         apb(1, 12'h034, {25'h1FFFFFF, c});
         apb(1, 12'h040, {29'h1FFFFFFF, p});
         apb(0, 12'h034, 0);
         chk(r, 32'(c));
         apb(0, 12'h040, 0);
         chk(r, 32'(p));
         chk(32'(pllRegulatorLevel), 32'(p));
         repeat (50) @(posedge ref_clk);
      end
      // status mirrors its inputs; writes there change nothing
      for (i = 0; i < 8; i++) begin
         st <= (i == 0) ? 7'h7F : (i == 1) ? 7'h0 : 7'($random(seed));
         repeat (3) @(posedge ref_clk);
         apb(1, 12'h030, 32'hFFFFFFFF);
         apb(0, 12'h030, 0);
         chk(r, exp_stat(st));
      end
      apb(0, 12'h038, 0);
      chk(32'(e), 32'h1);
      // a write with its low byte strobe off must leave the level alone
      ps <= 4'hE;
      apb(1, 12'h034, {25'h0000000, ~c});
      ps <= 4'hF;
      apb(0, 12'h034, 0);
      chk(r, 32'(c));
      // oscillator event: masked, then unmasked, then cleared by a read
      st <= 7'h0;
      apb(0, 12'h050, 0);
      st <= 7'h40;
      repeat (4) @(posedge ref_clk);
      chk(32'(irq), 32'h0);
      apb(1, 12'h054, 32'h40);
      repeat (2) @(posedge ref_clk);
      chk(32'(irq), 32'h1);
      apb(0, 12'h050, 0);
      chk(r, 32'h40);
      repeat (3) @(posedge ref_clk);
      chk(32'(irq), 32'h0);
      // second reset with the other strap: levels must reload from strap 0
      nrst <= 0;
      ms <= 2'h0;
      repeat (3) @(posedge ref_clk);
      nrst <= 1;
      repeat (2) @(posedge ref_clk);
      chk(32'(irq), 32'h0);
      apb(0, 12'h034, 0);
      chk(r, 32'h11);
      apb(0, 12'h040, 0);
      chk(r, 32'h2);
      print_verdict();
   end
endmodule // tb_power_supply_status_level_regs
`default_nettype wire
